// ### verilog/cscs_pkg.sv
// Package for the card slot control strobe controller.
// Assumes a single 125 MHz clock and synchronous active-high reset.
package cscs_pkg;
  localparam int          CSCS_CLK_MHZ        = 125;
  localparam int          CSCS_SETUP_NS       = 30;
  localparam int          CSCS_STROBE_NS      = 300;
  localparam int          CSCS_HOLD_NS        = 30;
  localparam int          CSCS_ACK_NS         = 2000;
  // Least times round up to whole cycles
  localparam int          CSCS_SETUP_CYC  = (CSCS_SETUP_NS * CSCS_CLK_MHZ + 999) / 1000;
  localparam int          CSCS_STROBE_CYC = (CSCS_STROBE_NS * CSCS_CLK_MHZ + 999) / 1000;
  localparam int          CSCS_HOLD_CYC   = (CSCS_HOLD_NS * CSCS_CLK_MHZ + 999) / 1000;
  // Longest wait for the wait line to drop rounds down
  localparam int          CSCS_WAIT_MAX_CYC   = (CSCS_ACK_NS * CSCS_CLK_MHZ) / 1000;
  localparam int          CSCS_CNT_W          = 9;
  localparam logic [1:0]  CSCS_CMD_MEM_RD     = 2'h0;
  localparam logic [1:0]  CSCS_CMD_IO_RD      = 2'h1;
  localparam logic [1:0]  CSCS_CMD_IO_WR      = 2'h2;
  localparam logic [1:0]  CSCS_CMD_ATTR_RD    = 2'h3;
  typedef enum logic [2:0] {CSCS_IDLE, CSCS_SETUP, CSCS_STROBE, CSCS_HOLD} cscs_state_e;
endpackage

// ### verilog/cscs_sync.sv
// Two-flop synchroniser for card status pins.
// Assumes inputs arrive asynchronously to clk_sys.
`timescale 1ns/100ps
module cscs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### verilog/cscs_ctrl.sv
// Socket-side controller for the control strobes of a 16-bit card slot.
// Assumes host requests come from clk_sys logic; card pins are asynchronous.
`timescale 1ns/100ps
module cscs_ctrl
  import cscs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [1:0] req_cmd,
  input  wire logic [1:0] req_lanes,
  input  wire logic       io_mode,
  output logic            done_pulse,
  output logic            done_ack,
  output logic            done_timeout,
  output logic            even_byte_card_enable_n,
  output logic            odd_byte_card_enable_n,
  output logic            mem_read_strobe_n,
  output logic            io_read_strobe_n,
  output logic            io_write_strobe_n,
  output logic            attr_select_n,
  input  wire logic       io_read_acknowledge_n,
  input  wire logic       wait_n,
  input  wire logic       ready_irq_pin,
  output logic            card_ready,
  output logic            card_interrupt_request
);
  import cscs_pkg::*;

  cscs_state_e           state_r;
  logic [CSCS_CNT_W-1:0] cnt_r;
  logic [1:0]            cmd_r;
  logic                  setup_end;
  logic                  cyc_end;
  logic                  strobe_go;
  logic                  ack_seen_r;
  logic                  wait_seen_r;
  logic [2:0]            pins_s;
  logic                  ack_s;
  logic                  wait_s;
  logic                  rdy_s;

  cscs_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       ({io_read_acknowledge_n, wait_n, ready_irq_pin}),
    .q       (pins_s)
  );
  assign ack_s  = ~pins_s[2];
  assign wait_s = ~pins_s[1];
  assign rdy_s  = pins_s[0];

  function automatic logic [CSCS_CNT_W-1:0] cyc(input int n);
    cyc = CSCS_CNT_W'(n - 1);
  endfunction

  assign req_ready = (state_r == CSCS_IDLE);

  // Decoded once so enables, strobes and the report agree on edges
  always_comb begin
    setup_end = (state_r == CSCS_SETUP) && (cnt_r == '0);
    cyc_end   = (state_r == CSCS_HOLD) && (cnt_r == '0);
    // Strobe stays out exactly while the sequencer stays in strobe
    strobe_go = (state_r == CSCS_STROBE) && (cnt_r != '0) && (!wait_seen_r || wait_s);
  end

  // Cycle sequencer: setup, strobe (stretched by wait), hold
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r     <= CSCS_IDLE;
      cnt_r       <= '0;
      cmd_r       <= CSCS_CMD_MEM_RD;
      wait_seen_r <= 1'b0;
    end else begin
      case (state_r)
        CSCS_IDLE: begin
          if (req_valid) begin
            cmd_r   <= req_cmd;
            cnt_r   <= cyc(CSCS_SETUP_CYC);
            state_r <= CSCS_SETUP;
          end
        end
        CSCS_SETUP: begin
          if (cnt_r == '0) begin
            cnt_r       <= cyc(CSCS_STROBE_CYC);
            wait_seen_r <= 1'b0;
            state_r     <= CSCS_STROBE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        CSCS_STROBE: begin
          // Wait timeout guards against a stuck card hanging the host
          if (wait_s && (wait_seen_r || cnt_r != '0)) begin
            if (!wait_seen_r) begin
              wait_seen_r <= 1'b1;
              cnt_r       <= cyc(CSCS_WAIT_MAX_CYC);
            end else if (cnt_r == '0) begin
              cnt_r   <= cyc(CSCS_HOLD_CYC);
              state_r <= CSCS_HOLD;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end else if (cnt_r == '0 || wait_seen_r) begin
            cnt_r   <= cyc(CSCS_HOLD_CYC);
            state_r <= CSCS_HOLD;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        CSCS_HOLD: begin
          if (cnt_r == '0) begin
            state_r <= CSCS_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= CSCS_IDLE;
      endcase
    end
  end

  // Enables and attribute select span setup, strobe and hold
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      even_byte_card_enable_n <= 1'b1;
      odd_byte_card_enable_n  <= 1'b1;
      attr_select_n           <= 1'b1;
    end else if (state_r == CSCS_IDLE && req_valid) begin
      even_byte_card_enable_n <= ~req_lanes[0];
      odd_byte_card_enable_n  <= ~req_lanes[1];
      attr_select_n           <= (req_cmd == CSCS_CMD_MEM_RD);
    end else if (cyc_end) begin
      even_byte_card_enable_n <= 1'b1;
      odd_byte_card_enable_n  <= 1'b1;
      attr_select_n           <= 1'b1;
    end
  end

  // Strobes registered so they cannot glitch on the card pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_read_strobe_n <= 1'b1;
      io_read_strobe_n  <= 1'b1;
      io_write_strobe_n <= 1'b1;
    end else begin
      // Only one strobe can be selected since cmd_r is a single code
      mem_read_strobe_n <= 1'b1;
      io_read_strobe_n  <= 1'b1;
      io_write_strobe_n <= 1'b1;
      if (setup_end || strobe_go) begin
        case (cmd_r)
          CSCS_CMD_MEM_RD:  mem_read_strobe_n <= 1'b0;
          CSCS_CMD_ATTR_RD: mem_read_strobe_n <= 1'b0;
          CSCS_CMD_IO_RD:   io_read_strobe_n  <= 1'b0;
          CSCS_CMD_IO_WR:   io_write_strobe_n <= 1'b0;
          default:          mem_read_strobe_n <= 1'b1;
        endcase
      end
    end
  end

  // Acknowledge only counts while the read strobe is out
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_seen_r <= 1'b0;
    end else if (state_r == CSCS_SETUP) begin
      ack_seen_r <= 1'b0;
    end else if (!io_read_strobe_n && ack_s) begin
      ack_seen_r <= 1'b1;
    end
  end

  // Completion report: one-cycle done pulse; ack and timeout flags held until the next cycle ends
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_pulse   <= 1'b0;
      done_ack     <= 1'b0;
      done_timeout <= 1'b0;
    end else begin
      done_pulse <= cyc_end;
      if (cyc_end) begin
        done_ack     <= ack_seen_r;
        done_timeout <= wait_seen_r && wait_s;
      end
    end
  end

  // Shared line reads as ready only on a memory-only socket
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      card_ready <= 1'b0;
    end else begin
      card_ready <= !io_mode && rdy_s;
    end
  end

  // Same line reads as an active-low interrupt on an I/O socket
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      card_interrupt_request <= 1'b0;
    end else begin
      card_interrupt_request <= io_mode && !rdy_s;
    end
  end
endmodule

// ### sim/cscs_ctrl_assertions.sv
// Checker for the strobe controller ports.
// Assumes it is bound into cscs_ctrl.
`timescale 1ns/100ps
module cscs_ctrl_chk
  import cscs_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [1:0] req_cmd,
  input wire logic [1:0] req_lanes,
  input wire logic       io_mode,
  input wire logic       done_pulse,
  input wire logic       even_byte_card_enable_n,
  input wire logic       odd_byte_card_enable_n,
  input wire logic       mem_read_strobe_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic       attr_select_n,
  input wire logic       card_ready,
  input wire logic       card_interrupt_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  a_one_strobe_only: assert property ($countones({mem_read_strobe_n, io_read_strobe_n,
    io_write_strobe_n}) >= 2) else $error("two strobes low");
  a_even_lane_sel: assert property (s_take |=> even_byte_card_enable_n ==
    !$past(req_lanes[0])) else $error("even enable wrong");
  a_odd_lane_sel: assert property (s_take |=> odd_byte_card_enable_n ==
    !$past(req_lanes[1])) else $error("odd enable wrong");
  a_io_read_strobe: assert property ((s_take and req_cmd == CSCS_CMD_IO_RD)
    |-> ##[1:8] !io_read_strobe_n) else $error("no io read strobe");
  a_io_write_strobe: assert property ((s_take and req_cmd == CSCS_CMD_IO_WR)
    |-> ##[1:8] !io_write_strobe_n) else $error("no io write strobe");
  a_mem_read_strobe: assert property ((s_take and req_cmd == CSCS_CMD_MEM_RD)
    |-> ##[1:8] !mem_read_strobe_n) else $error("no mem read strobe");
  a_attr_for_common: assert property (s_take |=> attr_select_n ==
    ($past(req_cmd) == CSCS_CMD_MEM_RD)) else $error("attr select wrong");
  a_ready_mem_only: assert property (io_mode && $past(io_mode) |-> !card_ready)
    else $error("ready in io mode");
  a_irq_io_only: assert property (!io_mode && $past(!io_mode) |->
    !card_interrupt_request) else $error("irq in memory mode");
  a_done_one_cycle: assert property (done_pulse |=> !done_pulse) else $error("long done");
endmodule
bind cscs_ctrl cscs_ctrl_chk chk (.*);

// ### sim/cscs_card_model.sv
// Behavioural 16-bit card for the socket strobes.
// Assumes the bench sets busy, irq and stall.
`timescale 1ns/100ps
module cscs_card (
  input  wire logic io_read_strobe_n,
  input  wire logic io_mode,
  input  wire logic busy,
  input  wire logic irq,
  input  wire logic stall,
  output logic      io_read_acknowledge_n,
  output logic      wait_n,
  output logic      ready_irq_pin
);
  // Every address decodes, so each io read is acknowledged
  assign io_read_acknowledge_n = io_read_strobe_n;
  assign wait_n = !stall;
  assign ready_irq_pin = io_mode ? !irq : !busy;
endmodule

// ### sim/card_slot_control_strobes_tb.sv
// Self-checking bench for cscs_ctrl with a card model.
// Assumes the checker file is compiled alongside.
`timescale 1ns/100ps
module card_slot_control_strobes_tb;
  import cscs_pkg::*;
  logic clk_sys = 0, reset = 1, req_valid = 0, io_mode = 1, busy = 0, irq = 0, stall = 0;
  logic [1:0] req_cmd = 2'h0, req_lanes = 2'h0;
  logic req_ready, done_pulse, done_ack, done_timeout, ev_n, od_n, mr_n, ir_n, iw_n, at_n;
  logic ack_n, wait_n, pin, card_ready, card_irq;
  int num_errors = 0, checked = 0, n;
  // Row: cmd, lanes, strobes {mem,ior,iow}, attr
  logic [7:0] rows [5] = '{8'h37, 8'h5A, 8'hAC, 8'hF6, 8'h27};
  cscs_ctrl uut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_lanes(req_lanes), .io_mode(io_mode),
    .done_pulse(done_pulse), .done_ack(done_ack), .done_timeout(done_timeout),
    .even_byte_card_enable_n(ev_n), .odd_byte_card_enable_n(od_n),
    .mem_read_strobe_n(mr_n), .io_read_strobe_n(ir_n), .io_write_strobe_n(iw_n),
    .attr_select_n(at_n), .io_read_acknowledge_n(ack_n), .wait_n(wait_n),
    .ready_irq_pin(pin), .card_ready(card_ready), .card_interrupt_request(card_irq));
  cscs_card card (.io_read_strobe_n(ir_n), .io_mode(io_mode), .busy(busy), .irq(irq),
    .stall(stall), .io_read_acknowledge_n(ack_n), .wait_n(wait_n), .ready_irq_pin(pin));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [1:0] c, input logic [1:0] l);
    req_cmd = c;
    req_lanes = l;
    req_valid = 1;
    @(negedge clk_sys);
    req_valid = 0;
    for (n = 0; n < 20 && (mr_n & ir_n & iw_n); n++) @(negedge clk_sys);
  endtask
  task automatic finish_cycle;
    for (n = 0; n < 400 && !done_pulse; n++) @(negedge clk_sys);
    chk(8'(done_pulse), 8'h01);
    @(negedge clk_sys);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    chk({1'b0, ev_n, od_n, mr_n, ir_n, iw_n, at_n, req_ready}, 8'h7F); // RESET
    reset = 0;
    foreach (rows[i]) begin
      start(rows[i][7:6], rows[i][5:4]);
      chk({2'h0, mr_n, ir_n, iw_n, at_n, od_n, ev_n}, {2'h0, rows[i][3:0], ~rows[i][5:4]});
      finish_cycle();
      chk(8'(done_ack), 8'(rows[i][7:6] == CSCS_CMD_IO_RD));
    end
    stall = 1;
    start(CSCS_CMD_MEM_RD, 2'h3);
    repeat (60) @(negedge clk_sys);
    chk(8'(mr_n), 8'h00);
    stall = 0;
    finish_cycle();
    chk(8'(done_timeout), 8'h00);
    // Wait never released: cycle must end by timeout with strobe back high
    stall = 1;
    start(CSCS_CMD_IO_WR, 2'h3);
    finish_cycle();
    chk(8'({done_timeout, iw_n}), 8'h03);
    stall = 0;
    // Reset in mid-cycle, then a fresh read must run normally
    start(CSCS_CMD_IO_RD, 2'h1);
    reset = 1;
    repeat (2) @(negedge clk_sys);
    chk({ev_n, od_n, mr_n, ir_n, iw_n, at_n, req_ready, done_ack | done_timeout | done_pulse},
      8'hFE); // RESET
    reset = 0;
    start(CSCS_CMD_IO_RD, 2'h1);
    chk(8'({ir_n, ev_n, od_n}), 8'h01);
    finish_cycle();
    chk(8'(done_ack), 8'h01);
    io_mode = 0;
    busy = 1;
    repeat (6) @(negedge clk_sys);
    chk(8'({card_ready, card_irq}), 8'h00);
    busy = 0;
    repeat (6) @(negedge clk_sys);
    chk(8'({card_ready, card_irq}), 8'h02);
    io_mode = 1;
    irq = 1;
    repeat (6) @(negedge clk_sys);
    chk(8'({card_ready, card_irq}), 8'h01);
    irq = 0;
    repeat (6) @(negedge clk_sys);
    chk(8'({card_ready, card_irq}), 8'h00);
    close_out();
  end
endmodule
